//--- core/snf_ctrl.sv
/*
 * Controller that loads and unloads an external sixteen word nibble store through its pins.
 * Assumes the store (or a chain, or parallel lanes of it) is wired to the pin ports,
 * that its pins are asynchronous to clk_in, and a 250 MHz clk_in.
 */
`timescale 1ns/1ps
module snf_ctrl #(
	parameter int LANES = snf_pkg::LANES,
	parameter int DEPTH = snf_pkg::LOCAL_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_valid_in,
	input wire logic [snf_pkg::NIBBLE_W*LANES-1:0] wr_data_in,
	output logic wr_ready_out,
	output logic rd_valid_out,
	output logic [snf_pkg::NIBBLE_W*LANES-1:0] rd_data_out,
	input wire logic rd_ready_in,
	input wire logic clear_req_in,
	input wire logic bus_release_in,
	output logic clear_busy_out,
	output snf_pkg::snf_strobes_t strobes_out,
	output logic [snf_pkg::NIBBLE_W*LANES-1:0] push_data_out,
	input wire logic [LANES-1:0] input_ready_in,
	input wire logic [LANES-1:0] output_ready_flag_in,
	input wire logic [snf_pkg::NIBBLE_W*LANES-1:0] pop_data_in
);
	import snf_pkg::*;

	localparam int W = NIBBLE_W * LANES;

	// pin synchronisers; stage one is read only by stage two
	logic [LANES-1:0] dir_s1_q, dir_s2_q, dor_s1_q, dor_s2_q;
	logic [W-1:0] q_s1_q, q_s2_q;
	logic dir_all, dor_all;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dir_s1_q <= '0;
			dir_s2_q <= '0;
			dor_s1_q <= '0;
			dor_s2_q <= '0;
			q_s1_q <= '0;
			q_s2_q <= '0;
		end else begin
			dir_s1_q <= input_ready_in;
			dir_s2_q <= dir_s1_q;
			dor_s1_q <= output_ready_flag_in;
			dor_s2_q <= dor_s1_q;
			q_s1_q <= pop_data_in;
			q_s2_q <= q_s1_q;
		end
	end

	// a lane group is ready only when every lane is ready
	assign dir_all = &dir_s2_q;
	assign dor_all = &dor_s2_q;

	snf_push_t push_q, push_d;
	snf_pop_t pop_q, pop_d;
	snf_clr_t clr_q, clr_d;
	snf_strobes_t str_q, str_d;
	logic [CNT_W-1:0] pcnt_q, pcnt_d, ocnt_q, ocnt_d, ccnt_q, ccnt_d;
	logic [W-1:0] hold_q, hold_d;
	logic hold_valid_q, hold_valid_d;
	logic wr_ready_q, wr_ready_d;
	logic rd_valid_q, rd_valid_d;
	logic [W-1:0] rd_data_q, rd_data_d;
	logic busy_q, busy_d;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [W-1:0] fifo_out_data;
	logic release_q;
	// how long the store outputs have been enabled, one bit per cycle
	logic [1:0] en_age_q, en_age_d;

	assign release_q = str_q.output_enable;

	always_comb begin
		push_d = push_q;
		pop_d = pop_q;
		clr_d = clr_q;
		str_d = str_q;
		pcnt_d = pcnt_q;
		ocnt_d = ocnt_q;
		ccnt_d = ccnt_q;
		hold_d = hold_q;
		hold_valid_d = hold_valid_q;
		fifo_in_valid = 1'b0;
		en_age_d = {en_age_q[0], !str_q.output_enable};

		// master clear sequencer; starts only with both strobes at rest
		unique case (clr_q)
			CLR_IDLE: begin
				if (clear_req_in && push_q == PUSH_IDLE && pop_q == POP_IDLE) begin
					clr_d = CLR_PULSE;
					ccnt_d = '0;
					str_d.master_clear = 1'b1;
					hold_valid_d = 1'b0;
				end
			end
			CLR_PULSE: begin
				ccnt_d = ccnt_q + CNT_W'(1);
				if (ccnt_q == MR_HIGH_CYC - CNT_W'(1)) begin
					str_d.master_clear = 1'b0;
					clr_d = CLR_TAIL;
					ccnt_d = '0;
				end
			end
			CLR_TAIL: begin
				// let the flags reach their cleared levels before trusting them
				ccnt_d = ccnt_q + CNT_W'(1);
				if (ccnt_q == SO_SETTLE_CYC - CNT_W'(1)) begin
					clr_d = CLR_IDLE;
				end
			end
		endcase

		if (wr_valid_in && wr_ready_q) begin
			hold_d = wr_data_in;
			hold_valid_d = 1'b1;
		end

		// push: strobe high, hold data, then wait out the ready dip
		unique case (push_q)
			PUSH_IDLE: begin
				// a clear that starts in this cycle must not meet a rising push strobe
				if (hold_valid_q && dir_all && clr_d == CLR_IDLE) begin
					str_d.push_strobe = 1'b1;
					push_d = PUSH_HIGH;
					pcnt_d = '0;
				end
			end
			PUSH_HIGH: begin
				pcnt_d = pcnt_q + CNT_W'(1);
				if (pcnt_q == SI_HIGH_CYC - CNT_W'(1)) begin
					str_d.push_strobe = 1'b0;
					push_d = PUSH_HOLD;
				end
			end
			PUSH_HOLD: begin
				pcnt_d = pcnt_q + CNT_W'(1);
				if (pcnt_q == SI_HOLD_CYC - CNT_W'(1)) begin
					push_d = PUSH_IDLE;
					hold_valid_d = 1'b0;
				end
			end
		endcase

		// pop: capture the presented word, then a falling strobe discards it
		unique case (pop_q)
			POP_IDLE: begin
				str_d.output_enable = bus_release_in || clr_q != CLR_IDLE;
				// the synchronised data lag the enable by two stages; wait them out
				if (dor_all && !release_q && &en_age_q && !bus_release_in
						&& clr_d == CLR_IDLE && fifo_in_ready) begin
					fifo_in_valid = 1'b1;
					str_d.pop_strobe = 1'b0;
					pop_d = POP_LOW;
					ocnt_d = '0;
				end
			end
			POP_LOW: begin
				ocnt_d = ocnt_q + CNT_W'(1);
				if (ocnt_q == SO_LOW_CYC - CNT_W'(1)) begin
					str_d.pop_strobe = 1'b1;
					pop_d = POP_SETTLE;
				end
			end
			POP_SETTLE: begin
				// output ready may lag the strobe; do not act on a stale high
				ocnt_d = ocnt_q + CNT_W'(1);
				if (ocnt_q == SO_SETTLE_CYC - CNT_W'(1)) begin
					pop_d = POP_IDLE;
				end
			end
		endcase

		wr_ready_d = !hold_valid_d;
		busy_d = clr_d != CLR_IDLE;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			push_q <= PUSH_IDLE;
			pop_q <= POP_IDLE;
			clr_q <= CLR_PULSE;
			str_q <= STROBES_RST;
			pcnt_q <= '0;
			ocnt_q <= '0;
			ccnt_q <= '0;
			hold_q <= '0;
			hold_valid_q <= 1'b0;
			wr_ready_q <= 1'b0;
			busy_q <= 1'b1;
			en_age_q <= '0;
		end else begin
			push_q <= push_d;
			pop_q <= pop_d;
			clr_q <= clr_d;
			str_q <= str_d;
			pcnt_q <= pcnt_d;
			ocnt_q <= ocnt_d;
			ccnt_q <= ccnt_d;
			hold_q <= hold_d;
			hold_valid_q <= hold_valid_d;
			wr_ready_q <= wr_ready_d;
			busy_q <= busy_d;
			en_age_q <= en_age_d;
		end
	end

	snf_fifo #(
		.WIDTH(W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(fifo_in_valid),
		.in_data_in(q_s2_q),
		.in_ready_out(fifo_in_ready),
		.out_valid_out(fifo_out_valid),
		.out_data_out(fifo_out_data),
		.out_ready_in(fifo_out_ready)
	);

	// registered output stage so the read port comes from flip-flops
	assign fifo_out_ready = !rd_valid_q || rd_ready_in;

	always_comb begin
		rd_valid_d = rd_valid_q;
		rd_data_d = rd_data_q;
		if (fifo_out_ready) begin
			rd_valid_d = fifo_out_valid;
			rd_data_d = fifo_out_data;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
		end else begin
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
		end
	end

	assign wr_ready_out = wr_ready_q;
	assign rd_valid_out = rd_valid_q;
	assign rd_data_out = rd_data_q;
	assign clear_busy_out = busy_q;
	assign strobes_out = str_q;
	assign push_data_out = hold_q;

	default clocking dcb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_push_high_width: assert property ($rose(str_q.push_strobe) |-> str_q.push_strobe [*8])
		else $error("push strobe high too briefly");
	a_push_low_gap: assert property ($fell(str_q.push_strobe) |-> !str_q.push_strobe [*8])
		else $error("push strobe raised again too soon");
	a_push_needs_ready: assert property ($rose(str_q.push_strobe) |-> $past(dir_all))
		else $error("push strobe raised without input ready");
	a_pop_needs_ready: assert property ($fell(str_q.pop_strobe) |-> $past(dor_all))
		else $error("pop strobe fell without output ready");
	a_enable_order: assert property ($fell(str_q.output_enable) |-> str_q.pop_strobe)
		else $error("outputs enabled while pop strobe low");
	a_clear_width: assert property ($rose(str_q.master_clear) |-> str_q.master_clear [*8])
		else $error("master clear pulse too short");
	a_clear_push_low: assert property (str_q.master_clear |-> !str_q.push_strobe)
		else $error("push strobe high during master clear");
	a_clear_at_start: assert property (@(posedge clk_in)
		$fell(rst_in) |-> str_q.master_clear ##[1:60] !str_q.master_clear)
		else $error("no bounded master clear after reset");
	a_pop_data_settled: assert property ($fell(str_q.pop_strobe) |-> $past(&en_age_q))
		else $error("word captured before enabled outputs settled");

	c_push_done: cover property ($fell(str_q.push_strobe));
	c_pop_done: cover property ($rose(str_q.pop_strobe));
	c_fifo_full: cover property (!fifo_in_ready && dor_all);
	c_user_clear: cover property ($past(clear_req_in) && $rose(str_q.master_clear));
endmodule

//--- core/snf_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module snf_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic do_wr, do_rd;

	function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
	endfunction

	assign in_ready_out = (count_q != CNT_W'(DEPTH));
	assign out_valid_out = (count_q != '0);
	assign out_data_out = mem_q[rd_ptr_q];
	assign do_wr = in_valid_in && in_ready_out;
	assign do_rd = out_valid_out && out_ready_in;

	always_comb begin
		mem_d = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (do_wr) begin
			mem_d[wr_ptr_q] = in_data_in;
			wr_ptr_d = ptr_next(wr_ptr_q);
		end
		if (do_rd) begin
			rd_ptr_d = ptr_next(rd_ptr_q);
		end
		if (do_wr && !do_rd) begin
			count_d = count_q + CNT_W'(1);
		end else if (do_rd && !do_wr) begin
			count_d = count_q - CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		mem_q <= mem_d;
		if (rst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end
endmodule

//--- core/snf_pkg.sv
/*
 * Shared constants and types for the controller of the sixteen word nibble store.
 * Assumes a 250 MHz clock; all pin timing is counted in cycles of that clock.
 */
package snf_pkg;
	localparam int CLK_NS = 4;
	localparam int NIBBLE_W = 4;
	localparam int LANES = 1;
	localparam int LOCAL_DEPTH = 8;
	localparam int CNT_W = 8;

	// pin timing in ns as printed for the slowest supply
	localparam int SI_HIGH_NS = 200;
	localparam int SI_HOLD_NS = 350;
	localparam int SO_LOW_NS = 180;
	localparam int SO_SETTLE_NS = 370;
	localparam int MR_HIGH_NS = 220;

	function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		if (c < 1) begin
			c = 1;
		end
		return CNT_W'(c);
	endfunction

	localparam logic [CNT_W-1:0] SI_HIGH_CYC = ns_to_cyc(SI_HIGH_NS);
	localparam logic [CNT_W-1:0] SI_HOLD_CYC = ns_to_cyc(SI_HOLD_NS);
	localparam logic [CNT_W-1:0] SO_LOW_CYC = ns_to_cyc(SO_LOW_NS);
	localparam logic [CNT_W-1:0] SO_SETTLE_CYC = ns_to_cyc(SO_SETTLE_NS);
	localparam logic [CNT_W-1:0] MR_HIGH_CYC = ns_to_cyc(MR_HIGH_NS);

	typedef struct packed {
		logic master_clear;
		logic output_enable;
		logic pop_strobe;
		logic push_strobe;
	} snf_strobes_t;

	// reset levels: pop strobe rests high so that only a falling edge unloads
	localparam snf_strobes_t STROBES_RST = '{master_clear: 1'b1, output_enable: 1'b1,
		pop_strobe: 1'b1, push_strobe: 1'b0};

	typedef enum logic [1:0] {PUSH_IDLE, PUSH_HIGH, PUSH_HOLD} snf_push_t;
	typedef enum logic [1:0] {POP_IDLE, POP_LOW, POP_SETTLE} snf_pop_t;
	typedef enum logic [1:0] {CLR_IDLE, CLR_PULSE, CLR_TAIL} snf_clr_t;
endpackage

//--- verification/snf_ctrl_test.sv
/*
 * Self-checking bench: controller driving the store model.
 * Assumes package, design and model files are compiled first.
 */
`timescale 1ns/1ps
module snf_ctrl_test;
	import snf_pkg::*;
	typedef struct packed {
		logic [3:0] din;
		logic [3:0] dout;
	} snf_row_t;
	localparam snf_row_t ROWS [6] = '{8'h00, 8'hff, 8'haa, 8'h55, 8'h11, 8'h88};
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr_valid_in = 1'b0;
	logic [3:0] wr_data_in = 4'h0;
	logic rd_ready_in = 1'b0;
	logic clear_req_in = 1'b0;
	logic bus_release_in = 1'b0;
	logic wr_ready_out, rd_valid_out, clear_busy_out, input_ready, output_ready_flag, ok;
	logic [3:0] rd_data_out, push_data_out, pop_data;
	snf_strobes_t strobes_out;
	int failures = 0;
	int check_count = 0;
	int n;
	always #2 clk_in = ~clk_in;
	snf_ctrl #(.LANES(1), .DEPTH(8)) u_snf_ctrl (.clk_in(clk_in), .rst_in(rst_in),
		.wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out),
		.rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .rd_ready_in(rd_ready_in),
		.clear_req_in(clear_req_in), .bus_release_in(bus_release_in),
		.clear_busy_out(clear_busy_out), .strobes_out(strobes_out),
		.push_data_out(push_data_out), .input_ready_in(input_ready),
		.output_ready_flag_in(output_ready_flag), .pop_data_in(pop_data));
	snf_store_model u_snf_store_model (.strobes_in(strobes_out), .push_data_in(push_data_out),
		.input_ready_out(input_ready), .output_ready_flag_out(output_ready_flag),
		.pop_data_out(pop_data));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// a refused word times out quietly so a full store can be probed
	task automatic try_write(input logic [3:0] w, output logic acc);
		int i;
		@(posedge clk_in);
		#1;
		wr_valid_in = 1'b1;
		wr_data_in = w;
		i = 0;
		while (wr_ready_out !== 1'b1 && i < 1500) begin
			@(posedge clk_in);
			#1;
			i++;
		end
		acc = (wr_ready_out === 1'b1);
		// the next edge takes the word when ready stands high
		@(posedge clk_in);
		#1;
		wr_valid_in = 1'b0;
	endtask
	task automatic read_word(input logic [3:0] exp);
		int i;
		@(posedge clk_in);
		#1;
		rd_ready_in = 1'b1;
		i = 0;
		while (rd_valid_out !== 1'b1 && i < 3000) begin
			@(posedge clk_in);
			#1;
			i++;
		end
		if (rd_valid_out !== 1'b1) begin
			failures++;
			end_of_test();
		end else begin
			chk({4'h0, rd_data_out}, {4'h0, exp});
			@(posedge clk_in);
			#1;
			rd_ready_in = 1'b0;
		end
	endtask
	task automatic wait_clear();
		int i;
		i = 0;
		do begin
			@(posedge clk_in);
			#1;
			i++;
		end while (clear_busy_out !== 1'b0 && i < 400);
		if (clear_busy_out !== 1'b0) begin
			failures++;
			end_of_test();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		#1;
		chk({4'h0, strobes_out}, {4'h0, STROBES_RST});
		chk({7'h0, clear_busy_out}, 8'h01);
		chk({6'h0, wr_ready_out, rd_valid_out}, 8'h00);
		rst_in = 1'b0;
		wait_clear();
		chk({7'h0, output_ready_flag}, 8'h00);
		for (n = 0; n < 6; n++) begin
			try_write(ROWS[n].din, ok);
			chk({7'h0, ok}, 8'h01);
		end
		for (n = 0; n < 6; n++) begin
			read_word(ROWS[n].dout);
		end
		n = 0;
		ok = 1'b1;
		while (ok && n < 30) begin
			try_write(4'(n * 7 + 3), ok);
			n += ok;
		end
		chk(8'(u_snf_store_model.fill), 8'h10);
		chk({7'h0, input_ready}, 8'h00);
		u_snf_store_model.ripple_ns = 1500;
		for (int k = 0; k < n; k++) begin
			read_word(4'(k * 7 + 3));
			repeat ((k % 3) * 40) @(posedge clk_in);
		end
		u_snf_store_model.ripple_ns = 100;
		repeat (300) @(posedge clk_in);
		#1;
		chk({7'h0, rd_valid_out}, 8'h00);
		bus_release_in = 1'b1;
		try_write(4'h9, ok);
		try_write(4'h6, ok);
		repeat (300) @(posedge clk_in);
		#1;
		chk({7'h0, rd_valid_out}, 8'h00);
		chk({7'h0, output_ready_flag}, 8'h01);
		chk({7'h0, strobes_out.output_enable}, 8'h01);
		clear_req_in = 1'b1;
		@(posedge clk_in);
		#1;
		clear_req_in = 1'b0;
		repeat (5) @(posedge clk_in);
		wait_clear();
		chk(8'(u_snf_store_model.fill), 8'h00);
		chk({6'h0, input_ready, output_ready_flag}, 8'h02);
		bus_release_in = 1'b0;
		try_write(4'hc, ok);
		read_word(4'hc);
		repeat (300) @(posedge clk_in);
		#1;
		chk({7'h0, rd_valid_out}, 8'h00);
		chk(8'(u_snf_store_model.violations), 8'h00);
		end_of_test();
	end
endmodule

//--- verification/snf_store_model.sv
/*
 * Pin-level model of the sixteen word nibble store.
 * Assumes the controller drives the strobes; the bench may change ripple_ns.
 */
`timescale 1ns/1ps
module snf_store_model (
	input wire snf_pkg::snf_strobes_t strobes_in,
	input wire logic [3:0] push_data_in,
	output logic input_ready_out,
	output logic output_ready_flag_out,
	output logic [3:0] pop_data_out
);
	import snf_pkg::*;
	int ripple_ns = 100;
	int fill = 0;
	int violations = 0;
	logic [3:0] q[$];
	initial begin
		input_ready_out = 1'b1;
		output_ready_flag_out = 1'b0;
		pop_data_out = 4'h0;
	end
	always @(posedge strobes_in.push_strobe) begin
		if (strobes_in.master_clear) begin
			violations++;
		end else if (input_ready_out) begin
			q.push_back(push_data_in);
			fill = q.size();
			input_ready_out = 1'b0;
			#300;
			input_ready_out = (fill < 16);
		end
	end
	task automatic unload();
		if (output_ready_flag_out && fill > 0) begin
			q.delete(0);
			fill = q.size();
			output_ready_flag_out = 1'b0;
			if (fill == 15) begin
				input_ready_out = 1'b1;
			end
		end
	endtask
	always @(negedge strobes_in.pop_strobe) begin
		if (!strobes_in.output_enable) begin
			unload();
		end
	end
	always @(negedge strobes_in.output_enable) begin
		if (!strobes_in.pop_strobe) begin
			violations++;
			unload();
		end
	end
	// stored bits are deleted, never shown again
	always @(posedge strobes_in.master_clear) begin
		q.delete();
		fill = 0;
		output_ready_flag_out = 1'b0;
		input_ready_out = 1'b1;
	end
	always begin
		wait (fill > 0 && output_ready_flag_out == 1'b0 && strobes_in.master_clear == 1'b0);
		#(ripple_ns);
		output_ready_flag_out = (fill > 0 && strobes_in.master_clear == 1'b0);
	end
	// released outputs float: each event inverts the last value, so two events bring stale data back
	always @(fill, output_ready_flag_out, strobes_in.output_enable) begin
		if (strobes_in.output_enable === 1'b0 && fill > 0) begin
			pop_data_out = q[0];
		end else begin
			pop_data_out = ~pop_data_out;
		end
	end
endmodule
